// file: logic/iopcn_pkg.sv
`default_nettype none
package iopcn_pkg;
    // Register offsets (word index on the plain register port)
    localparam logic [3:0] IOPCN_OFF_DIR    = 4'h0;
    localparam logic [3:0] IOPCN_OFF_LATCH  = 4'h1;
    localparam logic [3:0] IOPCN_OFF_PINS   = 4'h2;
    localparam logic [3:0] IOPCN_OFF_ODSEL  = 4'h3;
    localparam logic [3:0] IOPCN_OFF_ADCFG  = 4'h4;
    localparam logic [3:0] IOPCN_OFF_CNENA  = 4'h5;
    localparam logic [3:0] IOPCN_OFF_CNENB  = 4'h6;
    localparam logic [3:0] IOPCN_OFF_CNPUA  = 4'h7;
    localparam logic [3:0] IOPCN_OFF_CNPUB  = 4'h8;
    localparam logic [3:0] IOPCN_OFF_FAULTA = 4'h9;
    localparam logic [3:0] IOPCN_OFF_STATUS = 4'hA;
    localparam logic [3:0] IOPCN_OFF_MASK   = 4'hB;
    localparam logic [3:0] IOPCN_OFF_CTRL   = 4'hC;
    // Reset values
    localparam logic [15:0] IOPCN_RST_DIR    = 16'hFFFF;
    localparam logic [15:0] IOPCN_RST_ADCFG  = 16'h0000;
    localparam logic [4:0]  IOPCN_RST_FAULTA = 5'h1F;
    // Fault selector codes
    localparam logic [4:0]  IOPCN_FSEL_MAX   = 5'h19;
    localparam logic [4:0]  IOPCN_FSEL_GND   = 5'h1F;
    // Field positions, widths and pin counts
    localparam int IOPCN_ADCFG_W   = 13;
    localparam int IOPCN_STS_CN    = 0;
    localparam int IOPCN_CTRL_ADMD = 0;
    localparam int IOPCN_CN_MAX    = 31;
    localparam int IOPCN_RP_NUM    = 26;
endpackage
`default_nettype wire

// file: logic/iopcn_port.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Open-drain bit per pin: pin drives low only, floats instead of high.
// - Analog/digital configuration resets to zero: shared pins start analog.
// - Reading pin values returns zero for pins configured analog.
// - Digital-configured pins are not sampled by the converter.
// - Reads and bit operations on pin register see pin levels, not latch.
// - Enabled input pin change raises a change-notify interrupt request.
// - Change detection works in sleep with clocks stopped, to wake device.
// - Up to 31 change-notify inputs, count set by CN_W, limit set by package.
// - Two enable registers, one bit per change-notify pin.
// - Two pull-up registers, one bit per pin, enabling weak pull-up.
// - 5-bit selector routes remappable pin to fault A; 11111 grounds; reset ones.
// - Config one: digital, read enabled, mux grounded; zero: analog.
// - Converter disabled: configuration ignored, shared pins act digital.
module iopcn_port #(
    parameter int PIN_W = 16,
    parameter int CN_W  = 31,
    parameter int RP_W  = 26
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    // Port pins
    input  wire logic [PIN_W-1:0]  pin_in,
    output logic      [PIN_W-1:0]  pin_out,
    output logic      [PIN_W-1:0]  pin_oe,
    // Analog side
    output logic      [iopcn_pkg::IOPCN_ADCFG_W-1:0] analog_sample_en,
    // Change notify pins
    input  wire logic [CN_W-1:0]   cn_in,
    output logic      [CN_W-1:0]   cn_pullup_en,
    // Remappable pins and fault A
    input  wire logic [RP_W-1:0]   rp_in,
    output logic                   capture_fault_a_input,
    // Interrupt and wake
    output logic                   irq,
    output logic                   cn_wake
);
    localparam int IOPCN_ADW = iopcn_pkg::IOPCN_ADCFG_W;

    // Elaboration checks: pins above the analog field must exist, since the
    // read mask fills them with ones, and the notify pins need both registers
    if (CN_W < 17 || CN_W > iopcn_pkg::IOPCN_CN_MAX) begin : g_bad_cn_w
        $error("CN_W out of range");
    end
    if (PIN_W <= IOPCN_ADW || PIN_W > 16) begin : g_bad_pin_w
        $error("PIN_W out of range");
    end
    if (RP_W != iopcn_pkg::IOPCN_RP_NUM) begin : g_bad_rp_w
        $error("RP_W must match selector range");
    end

    // Registers
    logic [PIN_W-1:0]     direction_control_ff;
    logic [PIN_W-1:0]     output_latch_ff;
    logic [PIN_W-1:0]     open_drain_select_ff;
    logic [IOPCN_ADW-1:0] analog_digital_config_low_ff;
    logic [15:0]          change_notify_enable_a_ff;
    logic [15:0]          change_notify_enable_b_ff;
    logic [15:0]          change_notify_pullup_a_ff;
    logic [15:0]          change_notify_pullup_b_ff;
    logic [4:0]           fault_a_pin_choice_ff;
    logic                 status_cn_ff;
    logic                 mask_cn_ff;
    logic                 converter_module_disable_ff;
    logic [CN_W-1:0]      cn_last_ff;
    logic [15:0]          reg_rdata_ff;
    logic                 fault_a_ff;

    // Decode
    wire wr_dir    = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_DIR);
    wire wr_latch  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_LATCH);
    wire wr_pins   = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_PINS);
    wire wr_odsel  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_ODSEL);
    wire wr_adcfg  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_ADCFG);
    wire wr_cnena  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_CNENA);
    wire wr_cnenb  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_CNENB);
    wire wr_cnpua  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_CNPUA);
    wire wr_cnpub  = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_CNPUB);
    wire wr_faulta = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_FAULTA);
    wire wr_mask   = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_MASK);
    wire wr_ctrl   = reg_wr && (reg_addr == iopcn_pkg::IOPCN_OFF_CTRL);
    wire rd_status = reg_rd && (reg_addr == iopcn_pkg::IOPCN_OFF_STATUS);

    // Effective digital mode per shared pin; disabled converter forces digital
    wire [IOPCN_ADW-1:0] pin_digital =
        analog_digital_config_low_ff | {IOPCN_ADW{converter_module_disable_ff}};
    wire [PIN_W-1:0] pin_digital_full =
        {{(PIN_W-IOPCN_ADW){1'b1}}, pin_digital};

    // Converter samples only analog pins; a digital pin's mux is grounded
    assign analog_sample_en = ~pin_digital;

    // Pin read path: analog pins read zero, digital pins read the pin itself
    wire [PIN_W-1:0] pin_read = pin_in & pin_digital_full;

    // Output drivers; open drain turns a high into a release
    assign pin_out = output_latch_ff & ~open_drain_select_ff;
    assign pin_oe  = ~direction_control_ff &
                     (~output_latch_ff | ~open_drain_select_ff);

    // Change-notify enables and pull-ups spread over the two register pairs
    wire [31:0] cn_en_all = {change_notify_enable_b_ff, change_notify_enable_a_ff};
    wire [31:0] cn_pu_all = {change_notify_pullup_b_ff, change_notify_pullup_a_ff};
    wire [CN_W-1:0] cn_en = cn_en_all[CN_W-1:0];
    assign cn_pullup_en = cn_pu_all[CN_W-1:0];

    // Change compare against last sample; combinational so wake needs no clock
    wire [CN_W-1:0] cn_diff = (cn_in ^ cn_last_ff) & cn_en;
    wire cn_event = |cn_diff;
    assign cn_wake = cn_event;

    // Fault A selector: codes above the pin range tie the input low; the
    // index is clamped so no code ever reads past the pin vector
    wire       fsel_valid = fault_a_pin_choice_ff <= iopcn_pkg::IOPCN_FSEL_MAX;
    wire [4:0] fsel_idx   = fsel_valid ? fault_a_pin_choice_ff : 5'h00;
    wire       fsel_pin   = rp_in[fsel_idx];
    wire nxt_fault_a = fsel_valid ? fsel_pin : 1'b0;
    assign capture_fault_a_input = fault_a_ff;

    // Sticky status: a new event wins over the read-clear
    wire nxt_status_cn = cn_event | (status_cn_ff & ~rd_status);
    assign irq = status_cn_ff & mask_cn_ff;

    // Per-register read values, zero-extended to the bus width
    wire [15:0] rv_dir    = 16'(direction_control_ff);
    wire [15:0] rv_latch  = 16'(output_latch_ff);
    wire [15:0] rv_pins   = 16'(pin_read);
    wire [15:0] rv_odsel  = 16'(open_drain_select_ff);
    wire [15:0] rv_adcfg  = 16'(analog_digital_config_low_ff);
    wire [15:0] rv_cnena  = change_notify_enable_a_ff;
    wire [15:0] rv_cnenb  = change_notify_enable_b_ff;
    wire [15:0] rv_cnpua  = change_notify_pullup_a_ff;
    wire [15:0] rv_cnpub  = change_notify_pullup_b_ff;
    wire [15:0] rv_faulta = 16'(fault_a_pin_choice_ff);
    wire [15:0] rv_status = 16'(status_cn_ff) << iopcn_pkg::IOPCN_STS_CN;
    wire [15:0] rv_mask   = 16'(mask_cn_ff) << iopcn_pkg::IOPCN_STS_CN;
    wire [15:0] rv_ctrl   = 16'(converter_module_disable_ff) << iopcn_pkg::IOPCN_CTRL_ADMD;

    // Read selects, one per mapped index
    wire sel_dir    = reg_addr == iopcn_pkg::IOPCN_OFF_DIR;
    wire sel_latch  = reg_addr == iopcn_pkg::IOPCN_OFF_LATCH;
    wire sel_pins   = reg_addr == iopcn_pkg::IOPCN_OFF_PINS;
    wire sel_odsel  = reg_addr == iopcn_pkg::IOPCN_OFF_ODSEL;
    wire sel_adcfg  = reg_addr == iopcn_pkg::IOPCN_OFF_ADCFG;
    wire sel_cnena  = reg_addr == iopcn_pkg::IOPCN_OFF_CNENA;
    wire sel_cnenb  = reg_addr == iopcn_pkg::IOPCN_OFF_CNENB;
    wire sel_cnpua  = reg_addr == iopcn_pkg::IOPCN_OFF_CNPUA;
    wire sel_cnpub  = reg_addr == iopcn_pkg::IOPCN_OFF_CNPUB;
    wire sel_faulta = reg_addr == iopcn_pkg::IOPCN_OFF_FAULTA;
    wire sel_status = reg_addr == iopcn_pkg::IOPCN_OFF_STATUS;
    wire sel_mask   = reg_addr == iopcn_pkg::IOPCN_OFF_MASK;
    wire sel_ctrl   = reg_addr == iopcn_pkg::IOPCN_OFF_CTRL;

    // AND-OR merge: the selects are one-hot, so no priority chain is built
    // and an unmapped index falls through to zero
    wire [15:0] nxt_rdata = ({16{sel_dir}}    & rv_dir)    |
                            ({16{sel_latch}}  & rv_latch)  |
                            ({16{sel_pins}}   & rv_pins)   |
                            ({16{sel_odsel}}  & rv_odsel)  |
                            ({16{sel_adcfg}}  & rv_adcfg)  |
                            ({16{sel_cnena}}  & rv_cnena)  |
                            ({16{sel_cnenb}}  & rv_cnenb)  |
                            ({16{sel_cnpua}}  & rv_cnpua)  |
                            ({16{sel_cnpub}}  & rv_cnpub)  |
                            ({16{sel_faulta}} & rv_faulta) |
                            ({16{sel_status}} & rv_status) |
                            ({16{sel_mask}}   & rv_mask)   |
                            ({16{sel_ctrl}}   & rv_ctrl);
    // Data stand only in the cycle after a read strobe, zero otherwise
    wire [15:0] nxt_reg_rdata = reg_rd ? nxt_rdata : 16'h0000;
    assign reg_rdata = reg_rdata_ff;

    // Next register values: a write replaces the field, otherwise it holds
    wire [PIN_W-1:0]     nxt_direction_control =
        wr_dir ? reg_wdata[PIN_W-1:0] : direction_control_ff;
    wire [PIN_W-1:0]     nxt_output_latch =
        (wr_latch || wr_pins) ? reg_wdata[PIN_W-1:0] : output_latch_ff;
    wire [PIN_W-1:0]     nxt_open_drain_select =
        wr_odsel ? reg_wdata[PIN_W-1:0] : open_drain_select_ff;
    wire [IOPCN_ADW-1:0] nxt_analog_digital_config_low =
        wr_adcfg ? reg_wdata[IOPCN_ADW-1:0] : analog_digital_config_low_ff;
    wire                 nxt_converter_module_disable =
        wr_ctrl ? reg_wdata[iopcn_pkg::IOPCN_CTRL_ADMD] : converter_module_disable_ff;
    wire [15:0]          nxt_change_notify_enable_a =
        wr_cnena ? reg_wdata : change_notify_enable_a_ff;
    wire [15:0]          nxt_change_notify_enable_b =
        wr_cnenb ? reg_wdata : change_notify_enable_b_ff;
    wire [15:0]          nxt_change_notify_pullup_a =
        wr_cnpua ? reg_wdata : change_notify_pullup_a_ff;
    wire [15:0]          nxt_change_notify_pullup_b =
        wr_cnpub ? reg_wdata : change_notify_pullup_b_ff;
    wire [4:0]           nxt_fault_a_pin_choice =
        wr_faulta ? reg_wdata[4:0] : fault_a_pin_choice_ff;
    wire                 nxt_mask_cn =
        wr_mask ? reg_wdata[iopcn_pkg::IOPCN_STS_CN] : mask_cn_ff;

    // Direction bits; reset leaves every pin an input so nothing is driven
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_control_ff <= iopcn_pkg::IOPCN_RST_DIR[PIN_W-1:0];
        end else begin
            direction_control_ff <= nxt_direction_control;
        end
    end

    // Output latch; a write to the pin register lands here as well
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_latch_ff <= '0;
        end else begin
            output_latch_ff <= nxt_output_latch;
        end
    end

    // Open-drain select per pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            open_drain_select_ff <= '0;
        end else begin
            open_drain_select_ff <= nxt_open_drain_select;
        end
    end

    // Analog/digital configuration; shared pins start analog
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            analog_digital_config_low_ff <= iopcn_pkg::IOPCN_RST_ADCFG[IOPCN_ADW-1:0];
        end else begin
            analog_digital_config_low_ff <= nxt_analog_digital_config_low;
        end
    end

    // Converter disable; while set the configuration above is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            converter_module_disable_ff <= 1'b0;
        end else begin
            converter_module_disable_ff <= nxt_converter_module_disable;
        end
    end

    // Change-notify enables, low pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            change_notify_enable_a_ff <= 16'h0000;
        end else begin
            change_notify_enable_a_ff <= nxt_change_notify_enable_a;
        end
    end

    // Change-notify enables, high pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            change_notify_enable_b_ff <= 16'h0000;
        end else begin
            change_notify_enable_b_ff <= nxt_change_notify_enable_b;
        end
    end

    // Weak pull-ups, low pins; software must drop them on driven pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            change_notify_pullup_a_ff <= 16'h0000;
        end else begin
            change_notify_pullup_a_ff <= nxt_change_notify_pullup_a;
        end
    end

    // Weak pull-ups, high pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            change_notify_pullup_b_ff <= 16'h0000;
        end else begin
            change_notify_pullup_b_ff <= nxt_change_notify_pullup_b;
        end
    end

    // Last-level store follows every pin so enabling later starts clean;
    // with the clock stopped it holds, which keeps the wake compare alive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cn_last_ff <= '0;
        end else begin
            cn_last_ff <= cn_in;
        end
    end

    // Fault selector code; reset grounds the fault input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_a_pin_choice_ff <= iopcn_pkg::IOPCN_RST_FAULTA;
        end else begin
            fault_a_pin_choice_ff <= nxt_fault_a_pin_choice;
        end
    end

    // Selected fault level, one cycle late to keep the output registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_a_ff <= 1'b0;
        end else begin
            fault_a_ff <= nxt_fault_a;
        end
    end

    // Sticky change status; a change in the read cycle survives the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_cn_ff <= 1'b0;
        end else begin
            status_cn_ff <= nxt_status_cn;
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_cn_ff <= 1'b0;
        end else begin
            mask_cn_ff <= nxt_mask_cn;
        end
    end

    // Read data register; the status read sees the value before its clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 16'h0000;
        end else begin
            reg_rdata_ff <= nxt_reg_rdata;
        end
    end
endmodule // iopcn_port
`default_nettype wire

// file: verification/iopcn_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module iopcn_port_chk #(
    parameter int PIN_W = 16,
    parameter int CN_W  = 31,
    parameter int RP_W  = 26
) (
    // Clock, reset and register port
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic [3:0]       reg_addr,
    input wire logic [15:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_rdata,
    // Pins, analog, notify, fault and interrupt
    input wire logic [PIN_W-1:0] pin_in,
    input wire logic [PIN_W-1:0] pin_out,
    input wire logic [PIN_W-1:0] pin_oe,
    input wire logic [12:0]      analog_sample_en,
    input wire logic [CN_W-1:0]  cn_in,
    input wire logic [CN_W-1:0]  cn_pullup_en,
    input wire logic [RP_W-1:0]  rp_in,
    input wire logic             capture_fault_a_input,
    input wire logic             irq,
    input wire logic             cn_wake
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Access decodes shared by the properties
    wire pins_rd = reg_rd && reg_addr == iopcn_pkg::IOPCN_OFF_PINS;
    wire sts_rd  = reg_rd && reg_addr == iopcn_pkg::IOPCN_OFF_STATUS;
    wire msk_wr  = reg_wr && reg_addr == iopcn_pkg::IOPCN_OFF_MASK;
    wire off_wr  = reg_wr && reg_addr == iopcn_pkg::IOPCN_OFF_CTRL && reg_wdata[0];
    // Upper pins are always digital, so they read the pin, not the latch
    a_pins_read: assert property (pins_rd |=> reg_rdata[15:13] == $past(pin_in[15:13]))
        else $error("digital pin read differs from pin level");
    a_analog_zero: assert property (pins_rd |=> (reg_rdata[12:0] & $past(analog_sample_en)) == 13'h0000)
        else $error("analog pin read not zero");
    a_irq_cause: assert property ($rose(irq) |-> $past(cn_wake) || $past(msk_wr))
        else $error("interrupt rose without a change");
    a_irq_clear: assert property (sts_rd && !cn_wake |=> !irq)
        else $error("status read did not clear interrupt");
    a_irq_hold: assert property (irq && !reg_rd && !reg_wr |=> irq)
        else $error("interrupt dropped without a read");
    a_wake_settle: assert property ($stable(cn_in) && !$past(reg_wr) |-> !cn_wake)
        else $error("change seen on a steady input");
    a_reset_vals: assert property ($rose(rst_n) |-> analog_sample_en == 13'h1FFF && pin_oe == '0)
        else $error("wrong state after reset");
    a_adc_off: assert property (off_wr |=> analog_sample_en == 13'h0000)
        else $error("converter off but pins still analog");
    // Main scenarios reached
    c_pins: cover property (pins_rd);
    c_irq: cover property ($rose(irq));
    c_off: cover property (off_wr);
endmodule // iopcn_port_chk
bind iopcn_port iopcn_port_chk #(.PIN_W(PIN_W), .CN_W(CN_W), .RP_W(RP_W)) chk_inst (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pin_in, .pin_out,
    .pin_oe, .analog_sample_en, .cn_in, .cn_pullup_en, .rp_in, .capture_fault_a_input,
    .irq, .cn_wake);
`default_nettype wire

// file: verification/iopcn_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module iopcn_pins_model (
    // From the port block
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [30:0] cn_pullup_en,
    // Outside world set by the bench
    input wire logic [15:0] ext_lvl,
    input wire logic [30:0] cn_drv,
    input wire logic [30:0] cn_lvl,
    // Levels seen by the block
    output logic     [15:0] pin_in,
    output logic     [30:0] cn_in
);
    // A released pin shows the outside level, so open drain high floats
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
    // An undriven notify pin follows its weak pull-up, else sinks low
    assign cn_in = (cn_drv & cn_lvl) | (~cn_drv & cn_pullup_en);
endmodule // iopcn_pins_model
`default_nettype wire

// file: verification/tb_iopcn_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_iopcn_port;
    logic        clk, rst_n, reg_wr, reg_rd, run, capture_fault_a_input, irq, cn_wake;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, ext_lvl;
    logic [12:0] analog_sample_en;
    logic [30:0] cn_in, cn_pullup_en, cn_drv, cn_lvl;
    logic [25:0] rp_in;
    int          n_mismatch, checks;
    int          cn_pin[2] = '{3, 30};
    int          fsel[5] = '{0, 13, 25, 26, 31};
    // Clock stops while run is low, standing in for sleep
    initial begin
        clk = 1'b0;
        forever #20 if (run) clk = ~clk;
    end
    iopcn_port iopcn_port_inst (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe, .analog_sample_en, .cn_in, .cn_pullup_en,
        .rp_in, .capture_fault_a_input, .irq, .cn_wake);
    iopcn_pins_model iopcn_pins_model_inst (.pin_out, .pin_oe, .cn_pullup_en, .ext_lvl,
        .cn_drv, .cn_lvl, .pin_in, .cn_in);
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One-cycle register strobes; writes land at the taking edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    // Bounded wait for the interrupt
    task automatic wait_irq;
        int k;
        for (k = 0; k < 5 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == 5) begin
            n_mismatch++;
            close_out();
        end
    endtask
    initial begin
        run = 1'b1; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
        reg_wdata = 16'h0000; ext_lvl = 16'hFFFF; cn_drv = '1; cn_lvl = '0; rp_in = '0;
        n_mismatch = 0; checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(analog_sample_en, 13'h1FFF);
        rd(iopcn_pkg::IOPCN_OFF_ADCFG, 16'h0000);
        rd(iopcn_pkg::IOPCN_OFF_FAULTA, 16'h001F);
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'hE000);
        wr(iopcn_pkg::IOPCN_OFF_ADCFG, 16'h1FFF);
        chk(analog_sample_en, 13'h0000);
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'hFFFF);
        // Outputs with two open-drain pins holding a one
        @(posedge clk) ext_lvl <= 16'h0000;
        wr(iopcn_pkg::IOPCN_OFF_DIR, 16'h0000);
        wr(iopcn_pkg::IOPCN_OFF_LATCH, 16'h00F0);
        wr(iopcn_pkg::IOPCN_OFF_ODSEL, 16'h0030);
        chk(pin_oe, 16'hFFCF);
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'h00C0);
        @(posedge clk) ext_lvl <= 16'h0030;
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'h00F0);
        // Converter disabled overrides the analog setting
        wr(iopcn_pkg::IOPCN_OFF_DIR, 16'hFFFF);
        wr(iopcn_pkg::IOPCN_OFF_ADCFG, 16'h0000);
        @(posedge clk) ext_lvl <= 16'hFFFF;
        wr(iopcn_pkg::IOPCN_OFF_CTRL, 16'h0001);
        chk(analog_sample_en, 13'h0000);
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'hFFFF);
        wr(iopcn_pkg::IOPCN_OFF_CTRL, 16'h0000);
        rd(iopcn_pkg::IOPCN_OFF_PINS, 16'hE000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        // Change notify on the lowest and highest enabled pins
        wr(iopcn_pkg::IOPCN_OFF_CNENA, 16'h0008);
        wr(iopcn_pkg::IOPCN_OFF_CNENB, 16'h4000);
        wr(iopcn_pkg::IOPCN_OFF_MASK, 16'h0001);
        foreach (cn_pin[j]) begin
            @(posedge clk) cn_lvl[cn_pin[j]] <= ~cn_lvl[cn_pin[j]];
            wait_irq();
            rd(iopcn_pkg::IOPCN_OFF_STATUS, 16'h0001);
            chk(irq, 1'b0);
        end
        @(posedge clk) cn_lvl[5] <= 1'b1;
        repeat (3) @(posedge clk);
        rd(iopcn_pkg::IOPCN_OFF_STATUS, 16'h0000);
        // Clock stopped: the change must still show
        @(posedge clk) run <= 1'b0;
        #60 cn_lvl[3] = ~cn_lvl[3];
        #100 chk(cn_wake, 1'b1);
        run = 1'b1;
        wait_irq();
        rd(iopcn_pkg::IOPCN_OFF_STATUS, 16'h0001);
        // Masked event keeps its status but no interrupt
        wr(iopcn_pkg::IOPCN_OFF_MASK, 16'h0000);
        @(posedge clk) cn_lvl[30] <= ~cn_lvl[30];
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        rd(iopcn_pkg::IOPCN_OFF_STATUS, 16'h0001);
        // Notify pins are released before any pull-up goes on
        @(posedge clk) cn_drv <= '0;
        wr(iopcn_pkg::IOPCN_OFF_CNPUA, 16'h0003);
        wr(iopcn_pkg::IOPCN_OFF_CNPUB, 16'h4000);
        chk(cn_pullup_en, 31'h40000003);
        // Fault selector: pin codes, top pin code and grounded codes
        foreach (fsel[j]) begin
            wr(iopcn_pkg::IOPCN_OFF_FAULTA, 16'(fsel[j]));
            @(posedge clk) rp_in <= ~(26'h0000001 << fsel[j]);
            repeat (2) @(posedge clk);
            #1 chk(capture_fault_a_input, 1'b0);
            @(posedge clk) rp_in <= 26'h0000001 << fsel[j];
            repeat (2) @(posedge clk);
            #1 chk(capture_fault_a_input, fsel[j] < 26);
        end
        close_out();
    end
endmodule // tb_iopcn_port
`default_nettype wire
